// >>> rtl/tdr_pkg.sv
// Package: constants and types of the test access and debug sync block
package tdr_pkg;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int IR_W   = 4;
    localparam int DR_W   = 32;
    localparam int ADDR_W = 12;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] CTRL_OFF   = 12'h000;
    localparam logic [ADDR_W-1:0] STATUS_OFF = 12'h004;

    // ----------------------------------------------------------------
    // Control fields and reset value
    // ----------------------------------------------------------------
    localparam int CTRL_OUT_EN_BIT = 0;
    localparam int CTRL_IN_EN_BIT  = 1;
    localparam logic [1:0] CTRL_RST = 2'h0;

    // ----------------------------------------------------------------
    // Status fields
    // ----------------------------------------------------------------
    localparam int ST_LOCK_BIT  = 0;
    localparam int ST_BOOT_BIT  = 1;
    localparam int ST_DRIVE_BIT = 2;
    localparam int ST_IR_LSB    = 4;
    localparam int ST_TAP_LSB   = 8;

    // ----------------------------------------------------------------
    // Security register and user word fields
    // ----------------------------------------------------------------
    localparam int SEC_NO_TAP_BIT  = 0;
    localparam int SEC_NO_OTP_BIT  = 13;
    localparam int SEC_NO_DBG_BIT  = 14;
    localparam int USER_ID_LSB     = 22;
    localparam int USER_ID_W       = 10;
    localparam int USER_UNUSED_W   = 10;
    localparam int USER_REV_W      = 12;

    // ----------------------------------------------------------------
    // Instructions
    // ----------------------------------------------------------------
    localparam logic [IR_W-1:0] I_EXTEST  = 4'h0;
    localparam logic [IR_W-1:0] I_IDCODE  = 4'h1;
    localparam logic [IR_W-1:0] I_USER    = 4'h2;
    localparam logic [IR_W-1:0] I_SAMPLE  = 4'h3;
    localparam logic [IR_W-1:0] I_CHIP    = 4'h4;
    localparam logic [IR_W-1:0] I_OTP     = 4'h5;
    localparam logic [IR_W-1:0] I_BYPASS  = 4'hf;
    localparam logic [IR_W-1:0] IR_CAP    = 4'h1;

    // ----------------------------------------------------------------
    // Controller states
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        TS_RESET  = 4'h0,
        TS_IDLE   = 4'h1,
        TS_SELDR  = 4'h2,
        TS_CAPDR  = 4'h3,
        TS_SHDR   = 4'h4,
        TS_EX1DR  = 4'h5,
        TS_PAUDR  = 4'h6,
        TS_EX2DR  = 4'h7,
        TS_UPDR   = 4'h8,
        TS_SELIR  = 4'h9,
        TS_CAPIR  = 4'ha,
        TS_SHIR   = 4'hb,
        TS_EX1IR  = 4'hc,
        TS_PAUIR  = 4'hd,
        TS_EX2IR  = 4'he,
        TS_UPIR   = 4'hf
    } tdr_tap_st_t;

endpackage : tdr_pkg

// >>> rtl/tdr_sync3.sv
// Three-stage synchroniser with agreement filter for outside inputs
module tdr_sync3 #(
    parameter int           W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         pclk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] flt;
    } tdr_sync_st_t;

    tdr_sync_st_t st_q;
    tdr_sync_st_t st_d;

    // A bit moves only once stages two and three agree
    always_comb begin
        st_d     = st_q;
        st_d.s1  = d;
        st_d.s2  = st_q.s1;
        st_d.s3  = st_q.s2;
        st_d.flt = (~(st_q.s2 ^ st_q.s3) & st_q.s3)
                 | ((st_q.s2 ^ st_q.s3) & st_q.flt);
    end

    always_ff @(posedge pclk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '{s1: RST, s2: RST, s3: RST, flt: RST};
        end else begin
            st_q <= st_d;
        end
    end

    assign q = st_q.flt;

endmodule : tdr_sync3

// >>> rtl/tdr_tap.sv
// Test access port, debug sync pin and global reset/boot sequencing
// Operation
// - One boundary-scan port supporting pin scan
// - Four-bit instruction, thirty-two-bit data path
// - Chip-level port reached behind boundary scan
// - Test reset low holds the controller in reset
// - Debug pin directions act only when enabled
// - Output mode: float, low only while breakpoint is hit
// - Input mode: falling pin requests debug mode
// - Identification word fixed, least bit one
// - User word top field from security bits
// - Unprogrammed user field reads all zeros
// - Global reset active low, asynchronous assertion
// - Boot starts only after PLL lock
// - Test-port-disable bit blocks tile access
// - OTP-disable bit blocks test-port OTP access
// - Global-debug-disable bit blocks debug pin
module tdr_tap
    import tdr_pkg::*;
#(
    parameter logic [3:0]  ID_VERSION = 4'h1,     // Arbitrary value
    parameter logic [15:0] ID_PART    = 16'h5a5a, // Arbitrary value
    parameter logic [10:0] ID_MANUF   = 11'h123,  // Arbitrary value
    parameter logic [11:0] SI_REV     = 12'h001   // Arbitrary value
) (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        glob_rst_n,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [tdr_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic                        tck,
    input  wire logic                        tms,
    input  wire logic                        tdi,
    input  wire logic                        trst_n,
    output logic                             tdo,
    output logic                             tdo_oe_n,
    input  wire logic                        dbg_i,
    output logic                             dbg_o,
    output logic                             dbg_oe_n,
    input  wire logic                        breakpoint_hit,
    output logic                             debug_req,
    input  wire logic [31:0]                 sec_reg,
    input  wire logic                        pll_lock,
    output logic                             boot_start,
    input  wire logic [tdr_pkg::DR_W-1:0]    bsr_in,
    output logic      [tdr_pkg::DR_W-1:0]    bsr_out,
    output logic                             extest_en,
    output logic                             chip_sel,
    output logic                             chip_tdi,
    output logic                             chip_step,
    input  wire logic                        chip_tdo,
    output logic                             otp_sel,
    input  wire logic [tdr_pkg::DR_W-1:0]    otp_rdata,
    output logic      [tdr_pkg::DR_W-1:0]    otp_wdata,
    output logic                             otp_wr
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        tdr_tap_st_t     st;
        logic [IR_W-1:0] ir;
        logic [IR_W-1:0] ir_sr;
        logic [DR_W-1:0] sr;
        logic [DR_W-1:0] bsr;
        logic            tck_prev;
        logic            dbg_prev;
        logic            tdo;
        logic            tdo_en;
        logic            otp_wr;
        logic            chip_step;
        logic            dbg_drv;
        logic            dbg_req;
        logic            boot;
        logic [1:0]      ctrl;
        logic [31:0]     rdata;
        logic            rdy;
        logic            err;
    } tdr_state_t;

    tdr_state_t q;
    tdr_state_t d;
    logic       rst_all_n;
    logic [5:0] pin_f;
    logic       tck_f;
    logic       tms_f;
    logic       tdi_f;
    logic       trst_f;
    logic       dbg_f;
    logic       lock_f;
    logic       tck_rise;
    logic       tck_fall;
    logic       no_dbg;

    // Global pin reset asserts at once, without a clock edge
    assign rst_all_n = presetn & glob_rst_n;

    // Pull-up on the debug pin idles it high
    tdr_sync3 #(
        .W   (6),
        .RST (6'h10)
    ) u_sync (
        .pclk  (pclk),
        .rst_n (rst_all_n),
        .d     ({pll_lock, dbg_i, trst_n, tdi, tms, tck}),
        .q     (pin_f)
    );

    assign {lock_f, dbg_f, trst_f, tdi_f, tms_f, tck_f} = pin_f;
    assign tck_rise = tck_f & ~q.tck_prev;
    assign tck_fall = ~tck_f & q.tck_prev;
    assign no_dbg   = sec_reg[SEC_NO_DBG_BIT];

    // ----------------------------------------------------------------
    // Decoding
    // ----------------------------------------------------------------
    function automatic logic chip_ok(input logic [IR_W-1:0] ir,
                                     input logic [31:0]     sec);
        chip_ok = (ir == I_CHIP) && !sec[SEC_NO_TAP_BIT];
    endfunction : chip_ok
    function automatic logic otp_ok(input logic [IR_W-1:0] ir,
                                    input logic [31:0]     sec);
        otp_ok = (ir == I_OTP) && !sec[SEC_NO_OTP_BIT];
    endfunction : otp_ok
    function automatic tdr_tap_st_t tap_next(input tdr_tap_st_t s,
                                             input logic        m);
        unique case (s)
            TS_RESET: tap_next = m ? TS_RESET : TS_IDLE;
            TS_IDLE:  tap_next = m ? TS_SELDR : TS_IDLE;
            TS_SELDR: tap_next = m ? TS_SELIR : TS_CAPDR;
            TS_CAPDR: tap_next = m ? TS_EX1DR : TS_SHDR;
            TS_SHDR:  tap_next = m ? TS_EX1DR : TS_SHDR;
            TS_EX1DR: tap_next = m ? TS_UPDR  : TS_PAUDR;
            TS_PAUDR: tap_next = m ? TS_EX2DR : TS_PAUDR;
            TS_EX2DR: tap_next = m ? TS_UPDR  : TS_SHDR;
            TS_UPDR:  tap_next = m ? TS_SELDR : TS_IDLE;
            TS_SELIR: tap_next = m ? TS_RESET : TS_CAPIR;
            TS_CAPIR: tap_next = m ? TS_EX1IR : TS_SHIR;
            TS_SHIR:  tap_next = m ? TS_EX1IR : TS_SHIR;
            TS_EX1IR: tap_next = m ? TS_UPIR  : TS_PAUIR;
            TS_PAUIR: tap_next = m ? TS_EX2IR : TS_PAUIR;
            TS_EX2IR: tap_next = m ? TS_UPIR  : TS_SHIR;
            TS_UPIR:  tap_next = m ? TS_SELDR : TS_IDLE;
        endcase
    endfunction : tap_next

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        d           = q;
        d.tck_prev  = tck_f;
        d.dbg_prev  = dbg_f;
        d.otp_wr    = 1'b0;
        d.chip_step = 1'b0;
        d.dbg_req   = 1'b0;
        // Controller, stepped by sampled test clock edges
        if (!trst_f) begin
            d.st = TS_RESET;
            d.ir = I_IDCODE;
        end else if (tck_rise) begin
            unique case (q.st)
                TS_CAPDR: begin
                    unique case (q.ir)
                        I_IDCODE: d.sr = {ID_VERSION, ID_PART,
                                          ID_MANUF, 1'b1};
                        I_USER:   d.sr = {sec_reg[31:USER_ID_LSB],
                                          {USER_UNUSED_W{1'b0}},
                                          SI_REV};
                        I_SAMPLE,
                        I_EXTEST: d.sr = bsr_in;
                        I_OTP:    d.sr = otp_ok(q.ir, sec_reg)
                                         ? otp_rdata : '0;
                        default:  d.sr = '0;
                    endcase
                end
                TS_SHDR: begin
                    if (q.ir inside {I_IDCODE, I_USER, I_SAMPLE,
                                     I_EXTEST}
                        || otp_ok(q.ir, sec_reg)) begin
                        d.sr = {tdi_f, q.sr[DR_W-1:1]};
                    end else begin
                        d.sr[0] = tdi_f;
                    end
                    d.chip_step = chip_ok(q.ir, sec_reg);
                end
                TS_UPDR: begin
                    if (q.ir == I_EXTEST) begin
                        d.bsr = q.sr;
                    end
                    d.otp_wr = otp_ok(q.ir, sec_reg);
                end
                TS_CAPIR: d.ir_sr = IR_CAP;
                TS_SHIR:  d.ir_sr = {tdi_f, q.ir_sr[IR_W-1:1]};
                TS_UPIR:  d.ir    = q.ir_sr;
                default: ;
            endcase
            d.st = tap_next(q.st, tms_f);
            if (d.st == TS_RESET) begin
                d.ir = I_IDCODE;
            end
        end
        // Output side changes only on falling test clock edges
        if (tck_fall) begin
            d.tdo_en = (q.st == TS_SHDR) || (q.st == TS_SHIR);
            if (q.st == TS_SHIR) begin
                d.tdo = q.ir_sr[0];
            end else if (chip_ok(q.ir, sec_reg)) begin
                d.tdo = chip_tdo;
            end else begin
                d.tdo = q.sr[0];
            end
        end
        // Debug pin, each direction only when enabled and not locked
        d.dbg_drv = q.ctrl[CTRL_OUT_EN_BIT] && breakpoint_hit
                  && !no_dbg;
        d.dbg_req = q.ctrl[CTRL_IN_EN_BIT] && !no_dbg && !q.dbg_drv
                  && q.dbg_prev && !dbg_f;
        // Booting waits for the PLL after bus or global reset release
        d.boot = q.boot || lock_f;
        // Bus slave: read data is latched in setup, answered in access
        d.rdy   = psel && !penable;
        d.err   = 1'b0;
        d.rdata = '0;
        if (psel && !penable) begin
            unique case (paddr)
                CTRL_OFF: d.rdata[1:0] = q.ctrl;
                STATUS_OFF: begin
                    d.rdata[ST_LOCK_BIT]  = lock_f;
                    d.rdata[ST_BOOT_BIT]  = q.boot;
                    d.rdata[ST_DRIVE_BIT] = q.dbg_drv;
                    d.rdata[ST_IR_LSB +: IR_W] = q.ir;
                    d.rdata[ST_TAP_LSB +: 4]   = q.st;
                    d.err = pwrite;
                end
                default: d.err = 1'b1;
            endcase
        end
        if (psel && penable && pwrite && q.rdy && !q.err
            && paddr == CTRL_OFF) begin
            d.ctrl = pwdata[1:0];
        end
    end

    always_ff @(posedge pclk or negedge rst_all_n) begin
        if (!rst_all_n) begin
            q <= '{st: TS_RESET, ir: I_IDCODE, ir_sr: IR_CAP,
                   ctrl: CTRL_RST, dbg_prev: 1'b1, default: '0};
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign prdata     = q.rdata;
    assign pready     = psel & penable & q.rdy;
    assign pslverr    = psel & penable & q.rdy & q.err;
    assign tdo        = q.tdo;
    assign tdo_oe_n   = ~q.tdo_en;
    assign dbg_o      = 1'b0;
    assign dbg_oe_n   = ~q.dbg_drv;
    assign debug_req  = q.dbg_req;
    assign boot_start = q.boot;
    assign bsr_out    = q.bsr;
    assign extest_en  = (q.ir == I_EXTEST);
    assign chip_sel   = chip_ok(q.ir, sec_reg);
    assign chip_tdi   = tdi_f;
    assign chip_step  = q.chip_step;
    assign otp_sel    = otp_ok(q.ir, sec_reg);
    assign otp_wdata  = q.sr;
    assign otp_wr     = q.otp_wr;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!rst_all_n);

    chk_trst_hold: assert property (!trst_f |=> q.st == TS_RESET)
        else $error("test reset did not hold controller");
    chk_ir_default: assert property (
        q.st == TS_RESET |-> q.ir == I_IDCODE)
        else $error("reset state without id instruction");
    chk_idcode_cap: assert property (
        tck_rise && trst_f && q.st == TS_CAPDR && q.ir == I_IDCODE
        |=> q.sr == {ID_VERSION, ID_PART, ID_MANUF, 1'b1})
        else $error("id word not captured");
    chk_user_cap: assert property (
        tck_rise && trst_f && q.st == TS_CAPDR && q.ir == I_USER
        |=> q.sr[31:USER_ID_LSB] == $past(sec_reg[31:USER_ID_LSB])
            && q.sr[USER_REV_W-1:0] == SI_REV)
        else $error("user word not captured");
    chk_tdo_fall: assert property (
        $changed(q.tdo) |-> $past(tck_fall))
        else $error("test output moved off a falling edge");
    chk_dbg_drive: assert property (
        q.ctrl[CTRL_OUT_EN_BIT] && breakpoint_hit && !no_dbg
        |=> !dbg_oe_n ##1 (dbg_oe_n || breakpoint_hit || $past(
            breakpoint_hit)))
        else $error("debug pin not driven at breakpoint");
    chk_dbg_block: assert property (
        no_dbg && $past(no_dbg) |-> dbg_oe_n && !debug_req)
        else $error("debug pin active while locked");
    chk_dbg_req: assert property (
        debug_req |-> $past(q.ctrl[CTRL_IN_EN_BIT])
                      && !$past(dbg_f, 1) && $past(dbg_f, 2))
        else $error("debug request without falling pin");
    chk_chip_block: assert property (
        sec_reg[SEC_NO_TAP_BIT] |-> !chip_sel ##1
        (!chip_step || !$past(sec_reg[SEC_NO_TAP_BIT])))
        else $error("chip port reached while disabled");
    chk_otp_block: assert property (
        sec_reg[SEC_NO_OTP_BIT] && $past(sec_reg[SEC_NO_OTP_BIT])
        |-> !otp_sel && !otp_wr)
        else $error("otp reached while disabled");
    chk_boot_wait: assert property (
        $rose(boot_start) |-> $past(lock_f))
        else $error("boot began before lock");
    chk_ir_capture: assert property (
        tck_rise && trst_f && q.st == TS_CAPIR
        |=> q.ir_sr == IR_CAP)
        else $error("instruction capture value wrong");

endmodule : tdr_tap

// >>> bench/tdr_jtag_host.sv
// Model of the outside scan controller driving the test pins
module tdr_jtag_host (
    input  wire logic pclk,
    input  wire logic tdo,
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    output logic      trst_n
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Pin driving
    // ------------------------------------------------------------
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        trst_n = 1'b0;  // Low through power-up
    end

    // Test reset held 120 ns, above the 100 ns minimum
    task automatic treset();
        trst_n <= 1'b0;
        repeat (12) @(posedge pclk);
        trst_n <= 1'b1;
        repeat (8) @(posedge pclk);
    endtask : treset

    // One period: 4 pclk low, 4 high; tdo read late in high phase
    // since the pin filter delays it by up to 5 pclk
    task automatic tick(input logic m, input logic d, output logic o);
        tms <= m;
        tdi <= d;
        repeat (4) @(posedge pclk);
        tck <= 1'b1;
        repeat (4) @(posedge pclk);
        o = tdo;
        tck <= 1'b0;
    endtask : tick

    // Scan from idle and back to idle, least bit first
    task automatic scan(input logic ir, input int n,
                        input logic [31:0] din, output logic [31:0] dout);
        logic o;
        dout = '0;
        tick(1'b1, 1'b0, o);
        if (ir) begin
            tick(1'b1, 1'b0, o);
        end
        tick(1'b0, 1'b0, o);
        tick(1'b0, 1'b0, o);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], o);
            dout[i] = o;
        end
        tick(1'b1, 1'b0, o);
        // Data line is not left at its last value between frames
        tick(1'b0, ~din[n-1], o);
        // The pin filter acts on the last rise five pclk after it
        repeat (3) @(posedge pclk);
    endtask : scan
endmodule : tdr_jtag_host

// >>> bench/tap_debug_sync_reset_tb_top.sv
// Self-checking bench of the test port, debug pin and reset logic
module tap_debug_sync_reset_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import tdr_pkg::*;

    // Arbitrary identity values for this bench
    localparam logic [3:0]  ID_V = 4'h3;
    localparam logic [15:0] ID_P = 16'h0c3c;
    localparam logic [10:0] ID_M = 11'h0a5;
    localparam logic [11:0] REV  = 12'h00b;

    logic        pclk, presetn, glob_rst_n, psel, penable, pwrite, pready;
    logic        pslverr, tck, tms, tdi, trst_n, tdo, tdo_oe_n, dbg_i;
    logic        dbg_o, dbg_oe_n, bp, debug_req, pll_lock, boot_start;
    logic        extest_en, chip_sel, chip_tdi, chip_step, otp_sel;
    logic        otp_wr, pin_low, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, sec_reg, bsr_out, otp_wdata, r, d;
    int          err_total, n_checks, req_cnt, wr_cnt;

    // Open-drain pin with pull-up
    assign dbg_i = !dbg_oe_n ? dbg_o : !pin_low;

    tdr_tap #(.ID_VERSION(ID_V), .ID_PART(ID_P), .ID_MANUF(ID_M),
              .SI_REV(REV)) tdr_tap_inst (
        .pclk(pclk), .presetn(presetn), .glob_rst_n(glob_rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tck(tck), .tms(tms), .tdi(tdi),
        .trst_n(trst_n), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .dbg_i(dbg_i),
        .dbg_o(dbg_o), .dbg_oe_n(dbg_oe_n), .breakpoint_hit(bp),
        .debug_req(debug_req), .sec_reg(sec_reg), .pll_lock(pll_lock),
        .boot_start(boot_start), .bsr_in(32'h1234_5678),
        .bsr_out(bsr_out), .extest_en(extest_en), .chip_sel(chip_sel),
        .chip_tdi(chip_tdi), .chip_step(chip_step), .chip_tdo(1'b0),
        .otp_sel(otp_sel), .otp_rdata(32'h0f0f_3c3c),
        .otp_wdata(otp_wdata), .otp_wr(otp_wr));

    tdr_jtag_host tdr_jtag_host_inst (
        .pclk(pclk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi),
        .trst_n(trst_n));

    // ------------------------------------------------------------
    // Clock, monitors, watchdog
    // ------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        if (debug_req === 1'b1) req_cnt++;
        if (otp_wr === 1'b1) wr_cnt++;
    end

    // About 2.5k cycles expected; cut off well past that
    initial begin
        #500_000;
        err_total++;
        tally_and_finish();
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the answer
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic boot();
        repeat (10) @(posedge pclk);
        chk("boot_early", 0, boot_start);
        pll_lock <= 1'b1;
        for (int k = 0; k < 20 && boot_start !== 1'b1; k++) @(posedge pclk);
        chk("boot_locked", 1, boot_start);
    endtask : boot

    task automatic ir(input logic [3:0] code);
        tdr_jtag_host_inst.scan(1'b1, 4, {28'h0, code}, d);
        chk("ir_capture", IR_CAP, d[3:0]);
    endtask : ir

    task automatic dr(input int n, input logic [31:0] din);
        tdr_jtag_host_inst.scan(1'b0, n, din, d);
    endtask : dr

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        {presetn, glob_rst_n, psel, penable, pwrite, bp, pll_lock} = '0;
        {paddr, pwdata, sec_reg} = '0;
        {pin_low, err_total, n_checks, req_cnt, wr_cnt} = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (8) @(posedge pclk);
        glob_rst_n <= 1'b1;  // Held 115 ns
        boot();
        apb(1'b0, CTRL_OFF, 0);
        chk("ctrl_rst", {30'h0, CTRL_RST}, r);
        apb(1'b1, STATUS_OFF, 32'h0000_00ff);
        chk("status_ro", 1, e);
        apb(1'b0, 12'h0f0, 0);
        chk("unmapped", 1, e);
        tdr_jtag_host_inst.treset();
        apb(1'b0, STATUS_OFF, 0);
        chk("tap_state", TS_RESET, r[ST_TAP_LSB+:4]);
        chk("ir_default", I_IDCODE, r[ST_IR_LSB+:4]);
        chk("lock_boot", 2'b11, r[1:0]);
        tdr_jtag_host_inst.tick(1'b0, 1'b0, e);
        dr(32, 0);
        chk("idcode", {ID_V, ID_P, ID_M, 1'b1}, d);
        chk("tdo_float", 1, tdo_oe_n);
        sec_reg <= {10'h2a5, 22'h0};
        ir(I_USER);
        dr(32, 0);
        chk("usercode", {10'h2a5, 10'h0, REV}, d);
        sec_reg <= '0;
        dr(32, 0);
        chk("usercode_blank", {20'h0, REV}, d);
        ir(I_BYPASS);
        dr(8, 32'h0000_00a5);
        chk("bypass", 32'h0000_004a, d);
        ir(I_EXTEST);
        chk("extest_en", 1, extest_en);
        dr(32, 32'hcafe_0001);
        chk("bsr_capture", 32'h1234_5678, d);
        chk("bsr_update", 32'hcafe_0001, bsr_out);
        sec_reg <= 32'h0000_0001;
        ir(I_CHIP);
        chk("chip_block", 0, chip_sel);
        sec_reg <= '0;
        @(posedge pclk);
        chk("chip_sel", 1, chip_sel);
        sec_reg <= 32'h0000_2000;
        ir(I_OTP);
        chk("otp_block", 0, otp_sel);
        dr(32, 32'h5555_aaaa);
        chk("otp_no_wr", 0, wr_cnt);
        sec_reg <= '0;
        dr(32, 32'h1357_9bdf);
        chk("otp_read", 32'h0f0f_3c3c, d);
        chk("otp_wdata", 32'h1357_9bdf, otp_wdata);
        chk("otp_wr", 1, wr_cnt);
        // Debug pin output mode
        apb(1'b1, CTRL_OFF, 32'h0000_0001);
        chk("float_idle", 1, dbg_oe_n);
        bp <= 1'b1;
        repeat (3) @(posedge pclk);
        chk("drive_low", 0, dbg_i);
        sec_reg <= 32'h0000_4000;
        repeat (3) @(posedge pclk);
        chk("dbg_block", 1, dbg_oe_n);
        sec_reg <= '0;
        apb(1'b1, CTRL_OFF, 32'h0000_0000);
        repeat (3) @(posedge pclk);
        chk("out_off", 1, dbg_oe_n);
        bp <= 1'b0;
        // Debug pin input mode, then with it switched off
        for (int m = 2; m >= 0; m -= 2) begin
            apb(1'b1, CTRL_OFF, m);
            pin_low <= 1'b1;
            repeat (10) @(posedge pclk);
            pin_low <= 1'b0;
            repeat (10) @(posedge pclk);
            chk("debug_req", 1, req_cnt);
        end
        // Global reset acts without waiting for an edge
        glob_rst_n <= 1'b0;
        pll_lock <= 1'b0;
        #2;
        chk("async_rst", 0, boot_start);
        repeat (12) @(posedge pclk);
        glob_rst_n <= 1'b1;
        boot();
        tally_and_finish();
    end
endmodule : tap_debug_sync_reset_tb_top
